// *** design/ees_pkg.sv ***
// Shared constants and types for the data EEPROM erase sequencer
package ees_pkg;
  localparam int CLK_NS        = 10;
  localparam int ERASE_WORD_NS = 1000;
  localparam int ERASE_WORD_CYC = (ERASE_WORD_NS + CLK_NS - 1) / CLK_NS;
  localparam int EE_WORDS      = 256;
  localparam int BUS_AW        = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_KEY    = 8'h04;
  localparam logic [7:0] OFS_PAGE   = 8'h08;
  localparam logic [7:0] OFS_WORK   = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;

  // Field positions
  localparam int CTRL_START_BIT = 15;
  localparam int CTRL_SIZE_LSB  = 0;
  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_LOCK_BIT  = 1;

  // Unlock key pair and reset values
  localparam logic [15:0] KEY_FIRST  = 16'h0055;
  localparam logic [15:0] KEY_SECOND = 16'h00AA;
  localparam logic [1:0]  SIZE_RST   = 2'b00;
  localparam logic [1:0]  STAT_RST   = 2'b00;
  localparam logic [1:0]  MASK_RST   = 2'b00;

  typedef enum logic [1:0] {
    ERASE_ALL   = 2'b00,
    ERASE_ONE   = 2'b01,
    ERASE_FOUR  = 2'b10,
    ERASE_EIGHT = 2'b11
  } ees_size_t;

  typedef enum logic [1:0] {
    KEY_IDLE  = 2'b00,
    KEY_HALF  = 2'b01,
    KEY_ARMED = 2'b10
  } ees_key_t;

  typedef struct packed {
    logic [BUS_AW-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
  } ees_avs_req_t;
endpackage : ees_pkg

// *** design/ees_erase_engine.sv ***
// Word-by-word erase engine driving the EEPROM array strobes
`timescale 1ns/1ps
module ees_erase_engine #(
  parameter int AW       = 8,
  parameter int WORD_CYC = ees_pkg::ERASE_WORD_CYC
) (
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          start,
  input  wire logic [AW-1:0] base,
  input  wire logic [AW:0]   count,
  output logic               busy,
  output logic               done,
  output logic               ee_erase_stb,
  output logic [AW-1:0]      ee_erase_addr
);
  initial begin
    if (WORD_CYC < 1 || WORD_CYC > 998 || AW < 4) $error("ees_erase_engine: bad parameters");
  end

  localparam int TW = $clog2(WORD_CYC + 1);
  localparam int WB = WORD_CYC + 2;

  typedef enum logic [0:0] {ENG_IDLE = 1'b0, ENG_RUN = 1'b1} ees_eng_t;

  ees_eng_t      st_q, st_d;
  logic [AW:0]   left_q, left_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic [AW-1:0] addr_q, addr_d;
  logic          stb_q, stb_d, done_q, done_d;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d   = st_q;
    left_d = left_q;
    tmr_d  = tmr_q;
    addr_d = addr_q;
    stb_d  = 1'b0;
    done_d = 1'b0;
    unique case (st_q)
      ENG_IDLE: begin
        if (start && count != '0) begin
          st_d   = ENG_RUN;
          left_d = count;
          addr_d = base;
          tmr_d  = TW'(WORD_CYC - 1);
          stb_d  = 1'b1;
        end
      end
      ENG_RUN: begin
        if (tmr_q != '0) begin
          tmr_d = tmr_q - 1'b1;
        end else if (left_q == (AW+1)'(1)) begin
          st_d   = ENG_IDLE;
          done_d = 1'b1;
          left_d = '0;
        end else begin
          left_d = left_q - 1'b1;
          addr_d = addr_q + 1'b1;
          tmr_d  = TW'(WORD_CYC - 1);
          stb_d  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q   <= ENG_IDLE;
      left_q <= '0;
      tmr_q  <= '0;
      addr_q <= '0;
      stb_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      left_q <= left_d;
      tmr_q  <= tmr_d;
      addr_q <= addr_d;
      stb_q  <= stb_d;
      done_q <= done_d;
    end
  end

  assign busy          = (st_q == ENG_RUN);
  assign done          = done_q;
  assign ee_erase_stb  = stb_q;
  assign ee_erase_addr = addr_q;

  a_single_word: assert property (@(posedge clk) disable iff (srst)
    (start && !busy && count == (AW+1)'(1)) |=> ##[1:WB] done)
    else $error("single-word erase did not finish in time");
  a_busy_till_done: assert property (@(posedge clk) disable iff (srst)
    done |-> !busy && $past(busy))
    else $error("done pulse without a preceding busy erase");
endmodule : ees_erase_engine

// *** design/ees_erase_seq.sv ***
// Register front end, unlock logic and interrupt for the EEPROM erase sequencer
`timescale 1ns/1ps
// Notes on behaviour
// - Software chooses between erasing the whole data array or only a few words.
// - The two-bit size field in the low bits of the control register picks the whole array or one, four or eight words.
// - Setting the start bit right after a valid unlock begins erasing the selected words.
// - The start bit reads set while erasing, then clears, and the done flag is set at the end.
module ees_erase_seq #(
  parameter int EE_WORDS = ees_pkg::EE_WORDS,
  parameter int WORD_CYC = ees_pkg::ERASE_WORD_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic [ees_pkg::BUS_AW-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  output logic                            irq,
  output logic                            ee_erase_stb,
  output logic      [$clog2(EE_WORDS)-1:0] ee_erase_addr
);
  localparam int AW = $clog2(EE_WORDS);

  initial begin
    if (EE_WORDS < 16 || (1 << AW) != EE_WORDS || AW > 23)
      $error("ees_erase_seq: EE_WORDS must be a power of two from 16 to 2**23");
  end

  ////////////////////////////////////////////////////////////////////////
  // Size decode, shared by the engine word count and the block base
  function automatic logic [AW:0] size_words(input logic [1:0] sel);
    unique case (ees_pkg::ees_size_t'(sel))
      ees_pkg::ERASE_ALL:   size_words = (AW+1)'(EE_WORDS);
      ees_pkg::ERASE_ONE:   size_words = (AW+1)'(1);
      ees_pkg::ERASE_FOUR:  size_words = (AW+1)'(4);
      ees_pkg::ERASE_EIGHT: size_words = (AW+1)'(8);
    endcase
  endfunction : size_words

  function automatic logic [AW-1:0] block_base(input logic [1:0] sel, input logic [AW-1:0] word);
    logic [AW:0] n;
    n = size_words(sel);
    block_base = word & ~(n[AW-1:0] - 1'b1);
    if (ees_pkg::ees_size_t'(sel) == ees_pkg::ERASE_ALL) block_base = '0;
  endfunction : block_base

  ////////////////////////////////////////////////////////////////////////
  ees_pkg::ees_avs_req_t req;
  assign req = '{address: avs_address, read: avs_read, write: avs_write, writedata: avs_writedata};

  logic                ack_q, ack_d;
  logic [31:0]         rdata_q, rdata_d;
  logic [1:0]          size_q, size_d;
  logic [7:0]          page_q, page_d;
  logic [15:0]         work_q, work_d;
  logic [1:0]          stat_q, stat_d;
  logic [1:0]          mask_q, mask_d;
  ees_pkg::ees_key_t   key_q, key_d;
  logic                wr_acc, rd_acc, launch, lock_evt;
  logic                eng_busy, eng_done;
  logic [AW-1:0]       word_addr;
  logic [23:0]         full_addr;

  // One wait state: the request is answered at the second edge it is seen
  assign avs_waitrequest = (req.read || req.write) && !ack_q;
  assign wr_acc          = req.write && ack_q;
  assign rd_acc          = req.read && ack_q;

  // Byte address, so the word index starts at bit 1
  assign full_addr = {page_q, work_q};
  assign word_addr = full_addr[AW:1];
  assign launch    = wr_acc && req.address == ees_pkg::OFS_CTRL && req.writedata[ees_pkg::CTRL_START_BIT]
                     && key_q == ees_pkg::KEY_ARMED && !eng_busy;
  // A start write that arrives locked is dropped and reported
  assign lock_evt  = wr_acc && req.address == ees_pkg::OFS_CTRL && req.writedata[ees_pkg::CTRL_START_BIT]
                     && !launch;

  always_comb begin
    ack_d   = (req.read || req.write) && !ack_q;
    rdata_d = rdata_q;
    size_d  = size_q;
    page_d  = page_q;
    work_d  = work_q;
    mask_d  = mask_q;
    key_d   = key_q;
    stat_d  = stat_q;
    if (req.read && !ack_q) begin
      unique case (req.address)
        ees_pkg::OFS_CTRL:   rdata_d = {16'h0000, eng_busy, 13'h0000, size_q};
        ees_pkg::OFS_PAGE:   rdata_d = {24'h00_0000, page_q};
        ees_pkg::OFS_WORK:   rdata_d = {16'h0000, work_q};
        ees_pkg::OFS_STATUS: rdata_d = {30'h0000_0000, stat_q};
        ees_pkg::OFS_MASK:   rdata_d = {30'h0000_0000, mask_q};
        default:             rdata_d = 32'h0000_0000;
      endcase
    end
    // Any write other than the next key step disarms, so the pair must be back to back
    if (wr_acc) begin
      key_d = ees_pkg::KEY_IDLE;
      unique case (req.address)
        ees_pkg::OFS_CTRL: begin
          if (!eng_busy) size_d = req.writedata[ees_pkg::CTRL_SIZE_LSB +: 2];
        end
        ees_pkg::OFS_KEY: begin
          if (req.writedata[15:0] == ees_pkg::KEY_FIRST) key_d = ees_pkg::KEY_HALF;
          else if (req.writedata[15:0] == ees_pkg::KEY_SECOND && key_q == ees_pkg::KEY_HALF)
            key_d = ees_pkg::KEY_ARMED;
        end
        ees_pkg::OFS_PAGE: page_d = req.writedata[7:0];
        ees_pkg::OFS_WORK: work_d = req.writedata[15:0];
        ees_pkg::OFS_MASK: mask_d = req.writedata[1:0];
        default: ;
      endcase
    end
    // Clear only what the read returned, so a same-cycle event survives
    if (rd_acc && req.address == ees_pkg::OFS_STATUS) stat_d = stat_q & ~rdata_q[1:0];
    stat_d[ees_pkg::STAT_DONE_BIT] = stat_d[ees_pkg::STAT_DONE_BIT] | eng_done;
    stat_d[ees_pkg::STAT_LOCK_BIT] = stat_d[ees_pkg::STAT_LOCK_BIT] | lock_evt;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      size_q  <= ees_pkg::SIZE_RST;
      page_q  <= 8'h00;
      work_q  <= 16'h0000;
      stat_q  <= ees_pkg::STAT_RST;
      mask_q  <= ees_pkg::MASK_RST;
      key_q   <= ees_pkg::KEY_IDLE;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
      size_q  <= size_d;
      page_q  <= page_d;
      work_q  <= work_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      key_q   <= key_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign irq          = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////
  ees_erase_engine #(
    .AW       (AW),
    .WORD_CYC (WORD_CYC)
  ) u_engine (
    .clk           (clk),
    .srst          (srst),
    .start         (launch),
    .base          (block_base(size_q, word_addr)),
    .count         (size_words(size_q)),
    .busy          (eng_busy),
    .done          (eng_done),
    .ee_erase_stb  (ee_erase_stb),
    .ee_erase_addr (ee_erase_addr)
  );

  ////////////////////////////////////////////////////////////////////////
  a_launch_busy: assert property (@(posedge clk) disable iff (srst)
    launch |=> eng_busy && ee_erase_stb)
    else $error("unlocked start did not begin an erase");
  a_locked_start: assert property (@(posedge clk) disable iff (srst)
    (wr_acc && req.address == ees_pkg::OFS_CTRL && key_q != ees_pkg::KEY_ARMED && !eng_busy) |=> !eng_busy)
    else $error("start accepted without the unlock key");
  a_whole_erase: assert property (@(posedge clk) disable iff (srst)
    (launch && size_q == ees_pkg::ERASE_ALL) |=> ee_erase_addr == '0)
    else $error("whole erase did not start at word zero");
  a_done_flag: assert property (@(posedge clk) disable iff (srst)
    ($fell(eng_busy)) |=> stat_q[ees_pkg::STAT_DONE_BIT] && (irq || !mask_q[ees_pkg::STAT_DONE_BIT]))
    else $error("done flag missing after erase end");
  a_size_hold: assert property (@(posedge clk) disable iff (srst)
    eng_busy && $past(eng_busy) |-> $stable(size_q))
    else $error("size changed during an erase");
  // Unlock key bookkeeping and busy lockout
  a_key_consumed: assert property (@(posedge clk) disable iff (srst)
    launch |=> key_q == ees_pkg::KEY_IDLE)
    else $error("unlock key still armed after a start");
  a_key_disarm: assert property (@(posedge clk) disable iff (srst)
    (wr_acc && req.address != ees_pkg::OFS_KEY) |=> key_q == ees_pkg::KEY_IDLE)
    else $error("unlock key survived a foreign write");
  a_key_order: assert property (@(posedge clk) disable iff (srst)
    (wr_acc && req.address == ees_pkg::OFS_KEY && key_q != ees_pkg::KEY_HALF) |=> key_q != ees_pkg::KEY_ARMED)
    else $error("unlock key armed without its first half");
  a_busy_lock: assert property (@(posedge clk) disable iff (srst)
    (wr_acc && req.address == ees_pkg::OFS_CTRL && req.writedata[ees_pkg::CTRL_START_BIT] && eng_busy)
    |=> stat_q[ees_pkg::STAT_LOCK_BIT])
    else $error("start during an erase not flagged");
  a_size_blocked: assert property (@(posedge clk) disable iff (srst)
    (wr_acc && req.address == ees_pkg::OFS_CTRL && eng_busy) |=> $stable(size_q))
    else $error("size field written during an erase");
  // Erase strobes and the done pulse
  a_stb_idle: assert property (@(posedge clk) disable iff (srst)
    !eng_busy |-> !ee_erase_stb)
    else $error("erase strobe outside an erase");
  a_addr_step: assert property (@(posedge clk) disable iff (srst)
    (ee_erase_stb && !$past(launch)) |-> ee_erase_addr == AW'($past(ee_erase_addr) + 1'b1))
    else $error("erase address did not step by one word");
  a_done_once: assert property (@(posedge clk) disable iff (srst)
    eng_done |=> !eng_done)
    else $error("done pulse longer than one cycle");
  // Status, interrupt and bus answers
  a_status_sticky: assert property (@(posedge clk) disable iff (srst)
    (stat_q[ees_pkg::STAT_DONE_BIT] && !(rd_acc && req.address == ees_pkg::OFS_STATUS))
    |=> stat_q[ees_pkg::STAT_DONE_BIT])
    else $error("done flag lost without a status read");
  a_ctrl_busy_read: assert property (@(posedge clk) disable iff (srst)
    (rd_acc && req.address == ees_pkg::OFS_CTRL) |-> avs_readdata[ees_pkg::CTRL_START_BIT] == $past(eng_busy))
    else $error("start bit read does not follow the erase");
  a_irq_masked: assert property (@(posedge clk) disable iff (srst)
    (mask_q == 2'h0) |-> !irq)
    else $error("interrupt raised with every source masked");
  a_bus_answer: assert property (@(posedge clk) disable iff (srst)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest || !(avs_read || avs_write))
    else $error("bus request not answered after one wait state");
  a_read_stands: assert property (@(posedge clk) disable iff (srst)
    (avs_read && !avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed right after the answer");
endmodule : ees_erase_seq

// *** verif/ees_cpu_model.sv ***
// Software-side bus master issuing register accesses and erase sequences
`timescale 1ns/1ps
module ees_cpu_model (
  input  wire logic                       clk,
  input  wire logic [31:0]                avs_readdata,
  input  wire logic                       avs_waitrequest,
  output logic      [ees_pkg::BUS_AW-1:0] avs_address,
  output logic                            avs_read,
  output logic                            avs_write,
  output logic      [31:0]                avs_writedata
);
  logic timed_out = 1'b0;
  initial {avs_address, avs_read, avs_write, avs_writedata} = '0;
  ////////////////
  // Request held until waitrequest is sampled low, then dropped
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int          n;
    logic        ws;
    logic [31:0] rv;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= d;
    // Answer looked at mid-cycle, where it has settled; the next edge is the accept edge
    do begin
      @(negedge clk);
      n++;
      ws = avs_waitrequest;
      rv = avs_readdata;
      @(posedge clk);
    end while (ws !== 1'b0 && n < 40);
    if (n >= 40) timed_out = 1'b1;
    q = rv;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  ////////////////
  // Key mode 0 leaves the key out, 2 splits it with a foreign write
  task automatic erase(input logic [1:0] size, input logic [15:0] work, input int key_mode);
    wr(ees_pkg::OFS_CTRL, {30'h0, size});
    wr(ees_pkg::OFS_PAGE, 32'h0000_0000);
    wr(ees_pkg::OFS_WORK, {16'h0000, work});
    if (key_mode > 0) wr(ees_pkg::OFS_KEY, {16'h0000, ees_pkg::KEY_FIRST});
    if (key_mode == 2) wr(ees_pkg::OFS_PAGE, 32'h0000_0000);
    if (key_mode > 0) wr(ees_pkg::OFS_KEY, {16'h0000, ees_pkg::KEY_SECOND});
    // Start follows the key at once, nothing may slip in between
    wr(ees_pkg::OFS_CTRL, 32'h0000_8000 | {30'h0, size});
  endtask : erase
endmodule : ees_cpu_model

// *** verif/ees_erase_seq_bench.sv ***
// Self-checking bench for the EEPROM erase sequencer
`timescale 1ns/1ps
module ees_erase_seq_bench;
  localparam int WC = 6;
  localparam int EW = 16;
  logic        clk  = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest, irq, ee_erase_stb;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  ee_erase_addr;
  logic [3:0]  stb_addr[$];
  logic [7:0]  zero_ofs[4] = '{ees_pkg::OFS_CTRL, ees_pkg::OFS_STATUS, ees_pkg::OFS_MASK, 8'h18};
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  ////////////////
  ees_erase_seq #(.EE_WORDS(EW), .WORD_CYC(WC)) dut (
    .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .ee_erase_stb(ee_erase_stb),
    .ee_erase_addr(ee_erase_addr));
  ees_cpu_model cpu (
    .clk(clk), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata));
  always #5 clk = ~clk;
  // Strobe taken mid-cycle, clear of the edge that launches it
  always @(negedge clk) begin
    if (ee_erase_stb === 1'b1) stb_addr.push_back(ee_erase_addr);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  ////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    cpu.xfer(1'b0, a, 32'h0000_0000, d);
  endtask : rd
  task automatic conclude;
    mismatches += cpu.timed_out;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // Full keyed erase; strobe count, span, busy bit and done interrupt
  task automatic run(input logic [1:0] size, input logic [3:0] first, input int n, input logic ie);
    logic [31:0] d;
    int k;
    stb_addr.delete();
    cpu.erase(size, 16'h001A, 1);
    rd(ees_pkg::OFS_CTRL, d);
    check("busy", d[15], 1'b1);
    k = 0;
    while (d[15] !== 1'b0 && k < 300) begin
      rd(ees_pkg::OFS_CTRL, d);
      k++;
    end
    repeat (3) @(posedge clk);
    check("words", stb_addr.size(), n);
    check("first", stb_addr[0], first);
    check("last", stb_addr[$], int'(first) + n - 1);
    check("irq", irq, ie);
    rd(ees_pkg::OFS_STATUS, d);
    check("done", d, 32'h0000_0001);
    @(posedge clk);
    check("irq off", irq, 1'b0);
  endtask : run
  ////////////////
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check("irq rst", irq, 1'b0);
    cpu.wr(8'h18, 32'h0000_FFFF);
    foreach (zero_ofs[i]) begin
      rd(zero_ofs[i], q);
      check("reset", q, 32'h0000_0000);
    end
    cpu.wr(ees_pkg::OFS_MASK, 32'h0000_0003);
    rd(ees_pkg::OFS_MASK, q);
    check("mask", q, 32'h0000_0003);
    run(ees_pkg::ERASE_ONE, 4'hD, 1, 1'b1);
    run(ees_pkg::ERASE_FOUR, 4'hC, 4, 1'b1);
    run(ees_pkg::ERASE_EIGHT, 4'h8, 8, 1'b1);
    run(ees_pkg::ERASE_ALL, 4'h0, EW, 1'b1);
    // Missing key, then a key broken by another write
    for (int m = 0; m < 3; m += 2) begin
      stb_addr.delete();
      cpu.erase(ees_pkg::ERASE_ONE, 16'h001A, m);
      repeat (4) @(posedge clk);
      check("no stb", stb_addr.size(), 0);
      rd(ees_pkg::OFS_CTRL, q);
      check("no start", q[15], 1'b0);
      check("irq lock", irq, 1'b1);
      rd(ees_pkg::OFS_STATUS, q);
      check("locked", q, 32'h0000_0002);
    end
    // Start and size change while erasing: refused and flagged
    stb_addr.delete();
    cpu.erase(ees_pkg::ERASE_FOUR, 16'h001A, 1);
    cpu.wr(ees_pkg::OFS_CTRL, 32'h0000_8001);
    rd(ees_pkg::OFS_CTRL, q);
    check("busy size", q, 32'h0000_8002);
    repeat (40) @(posedge clk);
    check("busy words", stb_addr.size(), 4);
    rd(ees_pkg::OFS_STATUS, q);
    check("busy lock", q, 32'h0000_0003);
    cpu.wr(ees_pkg::OFS_MASK, 32'h0000_0000);
    run(ees_pkg::ERASE_EIGHT, 4'h8, 8, 1'b0);
    conclude();
  end
endmodule : ees_erase_seq_bench
